// [hdl/cfsf_pkg.sv]
// Shared constants and carrier types for the function state/force block
package cfsf_pkg;

    localparam int ADR_W = 12;
    localparam int DAT_W = 32;
    localparam int SYNC_STAGES = 3;

    // Register byte offsets
    localparam logic [11:0] OFS_EVENT = 12'h0F0;
    localparam logic [11:0] OFS_EVMASK = 12'h0F4;
    localparam logic [11:0] OFS_PRESENT = 12'h0F8;
    localparam logic [11:0] OFS_FORCE = 12'h0FC;
    localparam logic [11:0] OFS_CTRL = 12'h100;
    localparam logic [11:0] OFS_IRQ_STS = 12'h104;
    localparam logic [11:0] OFS_IRQ_MSK = 12'h108;

    // Field positions of the function registers
    localparam int BIT_FUNCTION_INTERRUPT_FLAG = 15;
    localparam int BIT_WKUP = 14;
    localparam int BIT_GENERAL_WAKEUP_FLAG = 4;
    localparam logic [31:0] FUNC_USED = 32'h0000_C010;

    // Control register: card mode enable and function register enable
    localparam int CTRL_CARD_EN = 3;
    localparam int CTRL_FUNC_EN = 1;

    // Block interrupt status/mask bits
    localparam int IRQ_N = 3;
    localparam int IRQ_PRES_FUNCTION_INTERRUPT_FLAG = 0;
    localparam int IRQ_PRES_GENERAL_WAKEUP_FLAG = 1;
    localparam int IRQ_FORCED = 2;

    // Reset values
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [2:0] EVMASK_RST = 3'h0;
    localparam logic [IRQ_N-1:0] IRQ_MSK_RST = 3'h0;
    localparam logic [DAT_W-1:0] RDAT_RST = 32'h0000_0000;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [ADR_W-1:0] adr;
        logic [3:0] sel;
        logic [DAT_W-1:0] dat;
    } cfsf_wb_req_t;

    typedef struct packed {
        logic ack;
        logic [DAT_W-1:0] dat;
    } cfsf_wb_rsp_t;

    typedef struct packed {
        logic function_interrupt_flag;
        logic general_wakeup_flag;
    } cfsf_func_t;

endpackage : cfsf_pkg

// [hdl/cfsf_sticky_bits.sv]
// Sticky flag bank: hardware set beats write-one-to-clear
`timescale 1ns/10ps

module cfsf_sticky_bits #(
    parameter int W = 2
) (
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic i_clk_en,
    input wire logic i_sync_clr,
    input wire logic [W-1:0] i_set,
    input wire logic [W-1:0] i_clr,
    output logic [W-1:0] o_q
);

    logic [W-1:0] flag_q;
    logic [W-1:0] flag_d;

    initial begin
        if (W < 1) $error("cfsf_sticky_bits: W must be at least 1");
    end

    always_comb begin
        flag_d = flag_q;
        if (i_clk_en) begin
            // Set listed last so a same-cycle event survives the clear
            flag_d = i_sync_clr ? '0 : (flag_q & ~i_clr);
            flag_d = flag_d | i_set;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            flag_q <= '0;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign o_q = flag_q;

    a_set_beats_clr: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        (i_clk_en && i_set[0] && i_clr[0]) |=> flag_q[0])
        else $error("sticky flag lost a same-cycle set");

endmodule : cfsf_sticky_bits

// [hdl/cfsf_func_state.sv]
// Function present-state and force-event registers behind a Wishbone slave
//
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/10ps

module cfsf_func_state #(
    parameter int ISR_W = 16
) (
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic i_clk_en,
    input wire logic i_hw_rst_pin_n,
    input wire cfsf_pkg::cfsf_wb_req_t i_wb,
    output cfsf_pkg::cfsf_wb_rsp_t o_wb,
    input wire logic [ISR_W-1:0] i_interrupt_status_register,
    input wire logic i_pme_status,
    output logic o_func_int,
    output logic o_card_status_change_pin,
    output logic o_irq
);

    initial begin
        if (ISR_W < 1 || ISR_W > 32) $error("cfsf_func_state: ISR_W must be 1..32");
    end

    function automatic logic hit(input logic [11:0] adr, input logic [11:0] ofs);
        hit = (adr[11:2] == ofs[11:2]);
    endfunction : hit

    function automatic logic [31:0] func_word(input logic function_interrupt_flag, input logic general_wakeup_flag);
        func_word = '0;
        func_word[cfsf_pkg::BIT_FUNCTION_INTERRUPT_FLAG] = function_interrupt_flag;
        func_word[cfsf_pkg::BIT_GENERAL_WAKEUP_FLAG] = general_wakeup_flag;
    endfunction : func_word

    // Reset pin synchroniser: a level counts once stages two and three agree
    logic [cfsf_pkg::SYNC_STAGES-1:0] pin_q;
    logic hw_rst_q;
    logic hw_rst_d;

    always_comb begin
        hw_rst_d = hw_rst_q;
        if (pin_q[1] == pin_q[2]) begin
            hw_rst_d = ~pin_q[2];
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pin_q <= '1;
            hw_rst_q <= 1'b0;
        end else if (i_clk_en) begin
            pin_q <= {pin_q[1:0], i_hw_rst_pin_n};
            hw_rst_q <= hw_rst_d;
        end
    end

    // Bus slave: ack one cycle after the request, write lands on the ack edge
    logic ack_q;
    logic ack_d;
    logic [31:0] rdat_q;
    logic [31:0] rdat_d;
    logic wr;
    logic en;

    cfsf_pkg::cfsf_func_t present_q;
    cfsf_pkg::cfsf_func_t present_d;
    logic [1:0] ev_q;
    logic [1:0] ev_set;
    logic [1:0] ev_clr;
    logic [2:0] evmask_q;
    logic [2:0] evmask_d;
    logic [1:0] ctrl_q;
    logic [1:0] ctrl_d;
    logic [cfsf_pkg::IRQ_N-1:0] sts_q;
    logic [cfsf_pkg::IRQ_N-1:0] sts_set;
    logic [cfsf_pkg::IRQ_N-1:0] sts_clr;
    logic [cfsf_pkg::IRQ_N-1:0] msk_q;
    logic [cfsf_pkg::IRQ_N-1:0] msk_d;
    logic func_int_d;
    logic wake_d;
    logic irq_d;
    logic func_int_q;
    logic wake_q;
    logic irq_q;
    logic wr_force;
    logic wr_event;
    logic lane0;
    logic lane1;

    assign en = ctrl_q[1] & ctrl_q[0];
    assign wr = i_clk_en & i_wb.cyc & i_wb.stb & i_wb.we & ack_q;
    assign lane0 = i_wb.sel[0];
    assign lane1 = i_wb.sel[1];
    assign wr_force = wr & en & hit(i_wb.adr, cfsf_pkg::OFS_FORCE);
    assign wr_event = wr & en & hit(i_wb.adr, cfsf_pkg::OFS_EVENT);

    always_comb begin
        ack_d = i_wb.cyc & i_wb.stb & ~ack_q;
        rdat_d = rdat_q;
        if (ack_d) begin
            rdat_d = '0;
            if (hit(i_wb.adr, cfsf_pkg::OFS_EVENT) && en) begin
                rdat_d = func_word(ev_q[1], ev_q[0]);
            end else if (hit(i_wb.adr, cfsf_pkg::OFS_EVMASK) && en) begin
                rdat_d = func_word(evmask_q[2], evmask_q[0]);
                rdat_d[cfsf_pkg::BIT_WKUP] = evmask_q[1];
            end else if (hit(i_wb.adr, cfsf_pkg::OFS_PRESENT) && en) begin
                rdat_d = func_word(present_q.function_interrupt_flag, present_q.general_wakeup_flag);
            end else if (hit(i_wb.adr, cfsf_pkg::OFS_CTRL)) begin
                rdat_d[cfsf_pkg::CTRL_CARD_EN] = ctrl_q[1];
                rdat_d[cfsf_pkg::CTRL_FUNC_EN] = ctrl_q[0];
            end else if (hit(i_wb.adr, cfsf_pkg::OFS_IRQ_STS)) begin
                rdat_d[cfsf_pkg::IRQ_N-1:0] = sts_q;
            end else if (hit(i_wb.adr, cfsf_pkg::OFS_IRQ_MSK)) begin
                rdat_d[cfsf_pkg::IRQ_N-1:0] = msk_q;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ack_q <= 1'b0;
            rdat_q <= cfsf_pkg::RDAT_RST;
        end else if (i_clk_en) begin
            ack_q <= ack_d;
            rdat_q <= rdat_d;
        end
    end

    assign o_wb.ack = ack_q;
    assign o_wb.dat = rdat_q;

    // Present state follows live sources only; a write to it has no path in
    always_comb begin
        present_d.function_interrupt_flag = |i_interrupt_status_register;
        present_d.general_wakeup_flag = i_pme_status;
    end

    // Power-on reset only: the pin reset must not touch these
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            present_q <= '0;
        end else if (i_clk_en) begin
            present_q <= present_d;
        end
    end

    // Event flags: force writes of 1 set, event writes of 1 clear
    always_comb begin
        ev_set = '0;
        ev_clr = '0;
        ev_set[1] = wr_force & lane1 & i_wb.dat[cfsf_pkg::BIT_FUNCTION_INTERRUPT_FLAG];
        ev_set[0] = (wr_force & lane0 & i_wb.dat[cfsf_pkg::BIT_GENERAL_WAKEUP_FLAG])
            | (present_d.general_wakeup_flag & ~present_q.general_wakeup_flag & i_clk_en);
        ev_clr[1] = wr_event & lane1 & i_wb.dat[cfsf_pkg::BIT_FUNCTION_INTERRUPT_FLAG];
        ev_clr[0] = wr_event & lane0 & i_wb.dat[cfsf_pkg::BIT_GENERAL_WAKEUP_FLAG];
    end

    // Pin reset deliberately not wired to the event bank
    cfsf_sticky_bits #(
        .W(2)
    ) u_event (
        .i_sys_clk(i_sys_clk),
        .i_resetn(i_resetn),
        .i_clk_en(i_clk_en),
        .i_sync_clr(1'b0),
        .i_set(ev_set),
        .i_clr(ev_clr),
        .o_q(ev_q)
    );

    // Block-level interrupt causes
    always_comb begin
        sts_set = '0;
        sts_clr = '0;
        sts_set[cfsf_pkg::IRQ_PRES_FUNCTION_INTERRUPT_FLAG] = present_d.function_interrupt_flag & ~present_q.function_interrupt_flag & i_clk_en;
        sts_set[cfsf_pkg::IRQ_PRES_GENERAL_WAKEUP_FLAG] = present_d.general_wakeup_flag & ~present_q.general_wakeup_flag & i_clk_en;
        sts_set[cfsf_pkg::IRQ_FORCED] = |ev_set & wr_force;
        if (wr && hit(i_wb.adr, cfsf_pkg::OFS_IRQ_STS) && lane0) begin
            sts_clr = i_wb.dat[cfsf_pkg::IRQ_N-1:0];
        end
    end

    cfsf_sticky_bits #(
        .W(cfsf_pkg::IRQ_N)
    ) u_irq_sts (
        .i_sys_clk(i_sys_clk),
        .i_resetn(i_resetn),
        .i_clk_en(i_clk_en),
        .i_sync_clr(hw_rst_q),
        .i_set(sts_set),
        .i_clr(sts_clr),
        .o_q(sts_q)
    );

    // Software registers; the event mask survives the pin reset
    always_comb begin
        evmask_d = evmask_q;
        ctrl_d = hw_rst_q ? cfsf_pkg::CTRL_RST : ctrl_q;
        msk_d = hw_rst_q ? cfsf_pkg::IRQ_MSK_RST : msk_q;
        if (wr && en && hit(i_wb.adr, cfsf_pkg::OFS_EVMASK)) begin
            if (lane1) begin
                evmask_d[2] = i_wb.dat[cfsf_pkg::BIT_FUNCTION_INTERRUPT_FLAG];
                evmask_d[1] = i_wb.dat[cfsf_pkg::BIT_WKUP];
            end
            if (lane0) begin
                evmask_d[0] = i_wb.dat[cfsf_pkg::BIT_GENERAL_WAKEUP_FLAG];
            end
        end
        if (wr && lane0 && hit(i_wb.adr, cfsf_pkg::OFS_CTRL)) begin
            ctrl_d = {i_wb.dat[cfsf_pkg::CTRL_CARD_EN], i_wb.dat[cfsf_pkg::CTRL_FUNC_EN]};
        end
        if (wr && lane0 && hit(i_wb.adr, cfsf_pkg::OFS_IRQ_MSK)) begin
            msk_d = i_wb.dat[cfsf_pkg::IRQ_N-1:0];
        end
        func_int_d = en & evmask_q[2] & (present_q.function_interrupt_flag | ev_q[1]);
        wake_d = en & evmask_q[1] & ((evmask_q[0] & ev_q[0]) | (evmask_q[2] & ev_q[1]));
        irq_d = |(sts_q & msk_q);
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            evmask_q <= cfsf_pkg::EVMASK_RST;
            ctrl_q <= cfsf_pkg::CTRL_RST;
            msk_q <= cfsf_pkg::IRQ_MSK_RST;
            func_int_q <= 1'b0;
            wake_q <= 1'b0;
            irq_q <= 1'b0;
        end else if (i_clk_en) begin
            evmask_q <= evmask_d;
            ctrl_q <= ctrl_d;
            msk_q <= msk_d;
            func_int_q <= func_int_d;
            wake_q <= wake_d;
            irq_q <= irq_d;
        end
    end

    assign o_func_int = func_int_q;
    assign o_card_status_change_pin = wake_q;
    assign o_irq = irq_q;

    // Checks
    logic rd_func_q;
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rd_func_q <= 1'b0;
        end else if (i_clk_en && ack_d) begin
            rd_func_q <= hit(i_wb.adr, cfsf_pkg::OFS_PRESENT) | hit(i_wb.adr, cfsf_pkg::OFS_FORCE);
        end
    end

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);

    a_function_interrupt_flag_sets: assert property ((i_clk_en && |i_interrupt_status_register)
        |=> present_q.function_interrupt_flag) else $error("present interrupt flag not set");
    a_function_interrupt_flag_clears: assert property ((i_clk_en && i_interrupt_status_register == '0)
        |=> !present_q.function_interrupt_flag) else $error("present interrupt flag not cleared");
    a_pin_keeps_ev: assert property ((hw_rst_q && i_clk_en && ev_set == '0
        && ev_clr == '0) |=> ev_q == $past(ev_q)) else $error("pin reset touched event flags");
    a_general_wakeup_flag_tracks: assert property (i_clk_en
        |=> present_q.general_wakeup_flag == $past(i_pme_status)) else $error("present wakeup off its source");
    a_general_wakeup_flag_holds: assert property ((present_q.general_wakeup_flag && i_pme_status && i_clk_en)
        |=> present_q.general_wakeup_flag [*1]) else $error("present wakeup dropped early");
    a_disabled_off: assert property ((!en && wr && !ev_q[1]
        && hit(i_wb.adr, cfsf_pkg::OFS_FORCE)) |=> !ev_q[1]) else $error("force while disabled");
    a_present_ro: assert property ((wr && hit(i_wb.adr, cfsf_pkg::OFS_PRESENT))
        |=> present_q.function_interrupt_flag == |$past(i_interrupt_status_register)) else $error("present written");
    a_force_function_interrupt_flag: assert property ((wr_force && lane1 && i_wb.dat[cfsf_pkg::BIT_FUNCTION_INTERRUPT_FLAG])
        |=> ev_q[1] ##1 !ack_q) else $error("forced interrupt not set");
    a_force_no_pres: assert property ((wr_force && i_interrupt_status_register == '0)
        |=> !present_q.function_interrupt_flag) else $error("force changed present interrupt");
    a_force_general_wakeup_flag: assert property ((wr_force && lane0 && i_wb.dat[cfsf_pkg::BIT_GENERAL_WAKEUP_FLAG])
        |=> ev_q[0]) else $error("forced wakeup not set");
    a_force_no_wake: assert property ((wr_force && !i_pme_status)
        |=> !present_q.general_wakeup_flag) else $error("force changed present wakeup");
    a_zero_ignored: assert property ((wr_force && !i_wb.dat[cfsf_pkg::BIT_FUNCTION_INTERRUPT_FLAG] && ev_q[1])
        |=> ev_q[1]) else $error("zero write cleared an event");
    a_w1c_clears: assert property ((wr_event && ev_clr[1] && !ev_set[1])
        |=> !ev_q[1]) else $error("event flag not cleared");
    a_mask_gates: assert property ((i_clk_en && !evmask_q[2])
        |=> !o_func_int) else $error("masked interrupt reached the line");
    a_reserved_zero: assert property ((ack_q && rd_func_q)
        |-> (o_wb.dat & ~cfsf_pkg::FUNC_USED) == '0) else $error("reserved bits read nonzero");
    a_ack_one: assert property (ack_q |=> !ack_q) else $error("ack held over two cycles");

    c_force_function_interrupt_flag: cover property (wr_force ##1 ev_q[1] ##[1:4] wr_event ##1 !ev_q[1]);
    c_func_int: cover property (present_q.function_interrupt_flag ##[1:8] o_func_int);
    c_wake_pin: cover property (o_card_status_change_pin);
    c_pin_reset: cover property (hw_rst_q && present_q.function_interrupt_flag);

endmodule : cfsf_func_state

// [dv/cfsf_host_model.sv]
// Host-side model: drives the status sources and latches the interrupt and wake lines
`timescale 1ns/10ps

module cfsf_host_model #(
    parameter int ISR_W = 16
) (
    input wire logic i_sys_clk,
    input wire logic i_func_int,
    input wire logic i_wake,
    output logic [ISR_W-1:0] o_isr,
    output logic o_pme
);
    logic int_seen_q;
    logic wake_seen_q;

    initial begin
        o_isr = {ISR_W{1'b0}};
        o_pme = 1'b0;
        int_seen_q = 1'b0;
        wake_seen_q = 1'b0;
    end

    // Sticky record, so a short pulse on either line is not missed
    always @(posedge i_sys_clk) begin
        if (i_func_int === 1'b1) begin
            int_seen_q <= 1'b1;
        end
        if (i_wake === 1'b1) begin
            wake_seen_q <= 1'b1;
        end
    end

    // Levels change only just after an edge; PM status holds until software drops it
    task automatic set_src(input logic [ISR_W-1:0] interrupt_status_register, input logic pme);
        @(posedge i_sys_clk);
        o_isr <= interrupt_status_register;
        o_pme <= pme;
    endtask : set_src
endmodule : cfsf_host_model

// [dv/cfsf_func_state_tb.sv]
// Self-checking bench for the function present-state and force-event block
`timescale 1ns/10ps

module cfsf_func_state_tb;
    logic i_sys_clk;
    logic i_resetn;
    logic i_clk_en;
    logic i_hw_rst_pin_n;
    cfsf_pkg::cfsf_wb_req_t wb_req;
    cfsf_pkg::cfsf_wb_rsp_t wb_rsp;
    logic [15:0] interrupt_status_register;
    logic pme;
    logic func_int;
    logic wake;
    logic irq;
    logic [15:0] rnd;
    logic [31:0] exp_q[$];
    int fails;
    int tests_run;

    cfsf_func_state #(.ISR_W(16)) DUT (
        .i_sys_clk(i_sys_clk),
        .i_resetn(i_resetn),
        .i_clk_en(i_clk_en),
        .i_hw_rst_pin_n(i_hw_rst_pin_n),
        .i_wb(wb_req),
        .o_wb(wb_rsp),
        .i_interrupt_status_register(interrupt_status_register),
        .i_pme_status(pme),
        .o_func_int(func_int),
        .o_card_status_change_pin(wake),
        .o_irq(irq)
    );

    cfsf_host_model #(.ISR_W(16)) host (
        .i_sys_clk(i_sys_clk),
        .i_func_int(func_int),
        .i_wake(wake),
        .o_isr(interrupt_status_register),
        .o_pme(pme)
    );

    initial begin
        i_sys_clk = 1'b0;
        forever #10 i_sys_clk = ~i_sys_clk;
    end

    task automatic summarize;
        if (fails == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : summarize

    // Read data is matched against the oldest note in the queue
    always @(negedge i_sys_clk) begin
        if (wb_rsp.ack === 1'b1 && wb_req.we === 1'b0) begin
            tests_run++;
            if (exp_q.size() == 0 || wb_rsp.dat !== exp_q[0]) begin
                fails++;
                $display("CHECK FAILED t=%0t read %h", $time, wb_rsp.dat);
            end
            if (exp_q.size() != 0) begin
                void'(exp_q.pop_front());
            end
        end
    end

    // Ack sampled at each rising edge; request released right after that edge
    task automatic bus(input logic we, input logic [11:0] adr, input logic [31:0] dat);
        int n;
        n = 0;
        @(posedge i_sys_clk);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: dat};
        do begin
            @(posedge i_sys_clk);
            n++;
        end while (wb_rsp.ack !== 1'b1 && n < 50);
        if (n < 50) begin
            wb_req <= '0;
        end else begin
            fails++;
            $display("CHECK FAILED t=%0t bus timeout", $time);
            summarize();
        end
    endtask : bus

    task automatic wr(input logic [11:0] adr, input logic [31:0] dat);
        bus(1'b1, adr, dat);
    endtask : wr

    task automatic rd(input logic [11:0] adr, input logic [31:0] exp);
        exp_q.push_back(exp);
        bus(1'b0, adr, 32'h0000_0000);
    endtask : rd

    task automatic tick(input int n);
        repeat (n) @(posedge i_sys_clk);
    endtask : tick

    task automatic chk(input logic got, input logic exp);
        @(negedge i_sys_clk);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t pin %b", $time, got);
        end
    endtask : chk

    initial begin
        fails = 0;
        tests_run = 0;
        i_resetn = 1'b0;
        i_clk_en = 1'b1;
        i_hw_rst_pin_n = 1'b1;
        wb_req = '0;
        void'($urandom(55));
        tick(20);
        i_resetn <= 1'b1;
        // Disabled block: force ignored, event register reads zero
        wr(cfsf_pkg::OFS_FORCE, 32'h0000_8010);
        rd(cfsf_pkg::OFS_EVENT, 32'h0000_0000);
        wr(cfsf_pkg::OFS_CTRL, 32'h0000_000A);
        wr(cfsf_pkg::OFS_IRQ_MSK, 32'h0000_0007);
        wr(cfsf_pkg::OFS_EVMASK, 32'h0000_C010);
        rnd = 16'($urandom()) | 16'h0001;
        host.set_src(rnd, 1'b0);
        tick(2);
        rd(cfsf_pkg::OFS_PRESENT, 32'h0000_8000);
        host.set_src(16'h8000, 1'b0);
        tick(2);
        rd(cfsf_pkg::OFS_PRESENT, 32'h0000_8000);
        host.set_src(16'h0000, 1'b0);
        tick(2);
        rd(cfsf_pkg::OFS_PRESENT, 32'h0000_0000);
        host.set_src(16'h0000, 1'b1);
        tick(2);
        rd(cfsf_pkg::OFS_PRESENT, 32'h0000_0010);
        wr(cfsf_pkg::OFS_PRESENT, 32'h0000_0000);
        rd(cfsf_pkg::OFS_PRESENT, 32'h0000_0010);
        rd(cfsf_pkg::OFS_EVENT, 32'h0000_0010);
        chk(wake, 1'b1);
        host.set_src(16'h0000, 1'b0);
        tick(2);
        rd(cfsf_pkg::OFS_PRESENT, 32'h0000_0000);
        wr(cfsf_pkg::OFS_EVENT, 32'h0000_0000);
        rd(cfsf_pkg::OFS_EVENT, 32'h0000_0010);
        wr(cfsf_pkg::OFS_EVENT, 32'h0000_0010);
        rd(cfsf_pkg::OFS_EVENT, 32'h0000_0000);
        wr(cfsf_pkg::OFS_FORCE, 32'h0000_0000);
        rd(cfsf_pkg::OFS_EVENT, 32'h0000_0000);
        wr(cfsf_pkg::OFS_FORCE, 32'h0000_8000);
        rd(cfsf_pkg::OFS_EVENT, 32'h0000_8000);
        rd(cfsf_pkg::OFS_PRESENT, 32'h0000_0000);
        chk(func_int, 1'b1);
        wr(cfsf_pkg::OFS_FORCE, 32'hFFFF_FFFF);
        rd(cfsf_pkg::OFS_EVENT, 32'h0000_8010);
        rd(cfsf_pkg::OFS_PRESENT, 32'h0000_0000);
        rd(cfsf_pkg::OFS_FORCE, 32'h0000_0000);
        wr(cfsf_pkg::OFS_EVMASK, 32'h0000_4010);
        tick(2);
        chk(func_int, 1'b0);
        // Block interrupt: raised, masked, cleared
        chk(irq, 1'b1);
        wr(cfsf_pkg::OFS_IRQ_MSK, 32'h0000_0000);
        tick(2);
        chk(irq, 1'b0);
        wr(cfsf_pkg::OFS_IRQ_MSK, 32'h0000_0007);
        wr(cfsf_pkg::OFS_IRQ_STS, 32'h0000_0007);
        tick(2);
        chk(irq, 1'b0);
        // Hardware reset pin must spare the present and event flags and the event mask
        host.set_src(16'h0004, 1'b1);
        tick(2);
        i_hw_rst_pin_n <= 1'b0;
        tick(5);
        i_hw_rst_pin_n <= 1'b1;
        tick(5);
        rd(cfsf_pkg::OFS_PRESENT, 32'h0000_0000);
        wr(cfsf_pkg::OFS_CTRL, 32'h0000_000A);
        rd(cfsf_pkg::OFS_PRESENT, 32'h0000_8010);
        rd(cfsf_pkg::OFS_EVENT, 32'h0000_8010);
        rd(cfsf_pkg::OFS_EVMASK, 32'h0000_4010);
        // Clock enable low: a wakeup rise while frozen must leave no trace
        host.set_src(16'h0000, 1'b0);
        wr(cfsf_pkg::OFS_EVENT, 32'h0000_8010);
        tick(2);
        i_clk_en <= 1'b0;
        host.set_src(16'h0000, 1'b1);
        tick(3);
        chk(wake, 1'b0);
        host.set_src(16'h0000, 1'b0);
        i_clk_en <= 1'b1;
        tick(2);
        rd(cfsf_pkg::OFS_EVENT, 32'h0000_0000);
        chk(host.int_seen_q, 1'b1);
        chk(host.wake_seen_q, 1'b1);
        rd(12'h200, 32'h0000_0000);
        tick(3);
        if (exp_q.size() != 0) begin
            fails++;
            $display("CHECK FAILED t=%0t reads missing", $time);
        end
        summarize();
    end
endmodule : cfsf_func_state_tb
